// [shared/dmaseq_pkg.sv]
// constants and types for the dma transfer sequencer
// Notes on behaviour
// - enabled request raises bus hold request
// - await grant, then acknowledge channel low
// - acknowledge is chip select; strobes move byte
// - transfer end: acknowledge high, hold request low
// - sample requests in state four, serve highest
// - higher priority preempts burst, then returns
// - hold request stays high while requests remain
// - grant removed: finish, drop hold request, idle
// - requests remain: reassert hold in fourth cycle
// - ready sampled in three; low enters wait
// - ready high advances to state four
// - four cycles per byte, no gaps
// - memory mapped cycle bits: 01 verify, 10 read, 11 illegal
package dmaseq_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 4;
  localparam logic [1:0] CYC_WRITE = 2'h0;
  localparam logic [1:0] CYC_VERIFY = 2'h1;
  localparam logic [1:0] CYC_READ = 2'h2;
  localparam logic [1:0] CYC_ILLEGAL = 2'h3;
  localparam logic [1:0] IDLE_GAP = 2'h2;
  typedef enum logic [2:0] {
    DMASEQ_IDLE = 3'h0,
    DMASEQ_WAIT_GRANT = 3'h1,
    DMASEQ_ONE = 3'h3,
    DMASEQ_TWO = 3'h2,
    DMASEQ_THREE = 3'h6,
    DMASEQ_WAITST = 3'h7,
    DMASEQ_FOUR = 3'h4,
    DMASEQ_GAP = 3'h5
  } dmaseq_state_t;
endpackage

// [hdl/dmaseq_fifo.sv]
// small valid/ready fifo for transfer data
`timescale 1ns/1ps
module dmaseq_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];
  assign push = clk_en && in_valid && in_ready;
  assign pop = clk_en && out_valid && out_ready;
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= AW'((wr_r + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_r <= AW'((rd_r + 1'b1) % DEPTH);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [hdl/dmaseq_top.sv]
// four channel dma transfer sequencer
`timescale 1ns/1ps
module dmaseq_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [3:0] transfer_request,
  input wire logic [3:0] chan_enable,
  input wire logic bus_hold_grant,
  input wire logic ready,
  input wire logic mem_mapped,
  input wire logic [1:0] cycle_bits,
  input wire logic [7:0] io_data,
  input wire logic mem_ready,
  output logic bus_hold_request,
  output logic [3:0] transfer_acknowledge_n,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic illegal_cycle,
  output logic data_stall,
  output logic [1:0] active_chan,
  output logic [7:0] mem_data,
  output logic mem_data_valid
);
  dmaseq_pkg::dmaseq_state_t state_r;
  logic [3:0] req_s1_r;
  logic [3:0] req_s2_r;
  logic grant_s1_r;
  logic grant_s2_r;
  logic ready_s1_r;
  logic ready_s2_r;
  logic [3:0] live_req;
  logic [1:0] chan_r;
  logic [1:0] gap_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic is_read;
  logic is_verify;
  logic is_illegal;

  // fixed priority picker, lowest index wins
  function automatic logic [1:0] pick(input logic [3:0] req);
    logic [1:0] w;
    w = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        w = 2'(i);
      end
    end
    return w;
  endfunction

  // request, grant and ready pins cross two flops before use
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_r <= 4'h0;
      req_s2_r <= 4'h0;
      grant_s1_r <= 1'b0;
      grant_s2_r <= 1'b0;
      ready_s1_r <= 1'b0;
      ready_s2_r <= 1'b0;
    end else if (clk_en) begin
      req_s1_r <= transfer_request;
      req_s2_r <= req_s1_r;
      grant_s1_r <= bus_hold_grant;
      grant_s2_r <= grant_s1_r;
      ready_s1_r <= ready;
      ready_s2_r <= ready_s1_r;
    end
  end

  assign live_req = req_s2_r & chan_enable;
  assign is_verify = mem_mapped && cycle_bits == dmaseq_pkg::CYC_VERIFY;
  assign is_read = mem_mapped && cycle_bits == dmaseq_pkg::CYC_READ;
  assign is_illegal = mem_mapped && cycle_bits == dmaseq_pkg::CYC_ILLEGAL;

  // transfer sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= dmaseq_pkg::DMASEQ_IDLE;
      chan_r <= 2'h0;
      gap_r <= 2'h0;
    end else if (clk_en) begin
      case (state_r)
        dmaseq_pkg::DMASEQ_IDLE: begin
          if (live_req != 4'h0) begin
            state_r <= dmaseq_pkg::DMASEQ_WAIT_GRANT;
          end
        end
        dmaseq_pkg::DMASEQ_WAIT_GRANT: begin
          if (live_req == 4'h0) begin
            state_r <= dmaseq_pkg::DMASEQ_IDLE;
          end else if (grant_s2_r) begin
            chan_r <= pick(live_req);
            state_r <= dmaseq_pkg::DMASEQ_ONE;
          end
        end
        dmaseq_pkg::DMASEQ_ONE: begin
          state_r <= dmaseq_pkg::DMASEQ_TWO;
        end
        dmaseq_pkg::DMASEQ_TWO: begin
          state_r <= dmaseq_pkg::DMASEQ_THREE;
        end
        dmaseq_pkg::DMASEQ_THREE, dmaseq_pkg::DMASEQ_WAITST: begin
          // a full data fifo stalls like a low ready
          if (ready_s2_r && fifo_in_ready) begin
            state_r <= dmaseq_pkg::DMASEQ_FOUR;
          end else begin
            state_r <= dmaseq_pkg::DMASEQ_WAITST;
          end
        end
        dmaseq_pkg::DMASEQ_FOUR: begin
          if (live_req == 4'h0) begin
            state_r <= dmaseq_pkg::DMASEQ_IDLE;
          end else if (!grant_s2_r) begin
            state_r <= dmaseq_pkg::DMASEQ_GAP;
            gap_r <= dmaseq_pkg::IDLE_GAP;
          end else begin
            chan_r <= pick(live_req);
            state_r <= dmaseq_pkg::DMASEQ_ONE;
          end
        end
        dmaseq_pkg::DMASEQ_GAP: begin
          if (gap_r == 2'h1) begin
            state_r <= dmaseq_pkg::DMASEQ_IDLE;
          end
          gap_r <= gap_r - 2'h1;
        end
        default: begin
          state_r <= dmaseq_pkg::DMASEQ_IDLE;
        end
      endcase
    end
  end

  // registered pin drive, decoded from next-cycle intent
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_hold_request <= 1'b0;
      transfer_acknowledge_n <= 4'hf;
      io_rd_n <= 1'b1;
      io_wr_n <= 1'b1;
      mem_rd_n <= 1'b1;
      mem_wr_n <= 1'b1;
      illegal_cycle <= 1'b0;
      active_chan <= 2'h0;
    end else if (clk_en) begin
      bus_hold_request <= state_r != dmaseq_pkg::DMASEQ_IDLE &&
        state_r != dmaseq_pkg::DMASEQ_GAP &&
        !(state_r == dmaseq_pkg::DMASEQ_FOUR &&
          (live_req == 4'h0 || !grant_s2_r)) ||
        (state_r == dmaseq_pkg::DMASEQ_IDLE && live_req != 4'h0);
      transfer_acknowledge_n <= 4'hf;
      io_rd_n <= 1'b1;
      io_wr_n <= 1'b1;
      mem_rd_n <= 1'b1;
      mem_wr_n <= 1'b1;
      active_chan <= chan_r;
      illegal_cycle <= is_illegal;
      if (state_r == dmaseq_pkg::DMASEQ_ONE ||
          state_r == dmaseq_pkg::DMASEQ_TWO ||
          state_r == dmaseq_pkg::DMASEQ_THREE ||
          state_r == dmaseq_pkg::DMASEQ_WAITST) begin
        transfer_acknowledge_n[chan_r] <= 1'b0;
        // verify runs acknowledge only; illegal moves nothing
        if (!is_verify && !is_illegal) begin
          if (is_read) begin
            mem_rd_n <= 1'b0;
            io_wr_n <= 1'b0;
          end else begin
            io_rd_n <= 1'b0;
            mem_wr_n <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_stall <= 1'b0;
      mem_data <= 8'h00;
      mem_data_valid <= 1'b0;
    end else if (clk_en) begin
      data_stall <= !fifo_in_ready;
      mem_data_valid <= fifo_out_valid && mem_ready;
      mem_data <= fifo_out_data;
    end
  end

  dmaseq_fifo #(
    .WIDTH(dmaseq_pkg::FIFO_W),
    .DEPTH(dmaseq_pkg::FIFO_D)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(state_r == dmaseq_pkg::DMASEQ_FOUR && !is_read &&
      !is_verify && !is_illegal),
    .in_ready(fifo_in_ready),
    .in_data(io_data),
    .out_valid(fifo_out_valid),
    .out_ready(mem_ready),
    .out_data(fifo_out_data)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  one_ack_a: assert property (
    clk_en |-> $countones(~transfer_acknowledge_n) <= 1)
    else $error("two acknowledges low");
  grant_wait_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_WAIT_GRANT && !grant_s2_r
    |=> state_r != dmaseq_pkg::DMASEQ_ONE)
    else $error("started without grant");
  ready_wait_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_THREE && !ready_s2_r
    |=> state_r == dmaseq_pkg::DMASEQ_WAITST)
    else $error("ready low ignored");
  ready_go_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_WAITST && ready_s2_r &&
    fifo_in_ready |=> state_r == dmaseq_pkg::DMASEQ_FOUR)
    else $error("ready high ignored");
  four_cycle_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_ONE ##1 clk_en[*2] ##0
    ready_s2_r && fifo_in_ready |-> ##1 state_r == dmaseq_pkg::DMASEQ_FOUR)
    else $error("transfer not four cycles");
  back_to_back_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_FOUR && grant_s2_r &&
    live_req != 4'h0 |=> state_r == dmaseq_pkg::DMASEQ_ONE &&
    chan_r == pick($past(live_req)))
    else $error("gap or wrong channel after four");
  grant_drop_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_FOUR && !grant_s2_r &&
    live_req != 4'h0 |=> state_r == dmaseq_pkg::DMASEQ_GAP ##1
    !bus_hold_request)
    else $error("no release");
  disabled_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_WAIT_GRANT && grant_s2_r &&
    live_req != 4'h0 |=> chan_enable[chan_r])
    else $error("disabled channel served");
  hold_low_a: assert property (
    clk_en && state_r == dmaseq_pkg::DMASEQ_FOUR && live_req == 4'h0
    |=> !bus_hold_request)
    else $error("hold stuck");

  burst_c: cover property (state_r == dmaseq_pkg::DMASEQ_FOUR ##1
    state_r == dmaseq_pkg::DMASEQ_ONE);
  wait_c: cover property (state_r == dmaseq_pkg::DMASEQ_WAITST);
  gap_c: cover property (state_r == dmaseq_pkg::DMASEQ_GAP);
endmodule

// [verif/dmaseq_host_model.sv]
// host bus grant and io device model facing the sequencer
`timescale 1ns/1ps
module dmaseq_host_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic bus_hold_request,
  input wire logic revoke,
  input wire logic [3:0] transfer_acknowledge_n,
  output logic bus_hold_grant,
  output logic [7:0] io_data
);
  logic [1:0] dly_r;
  // grant lags the hold request by two cycles; revoke takes the bus back
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) dly_r <= 2'h0;
    else dly_r <= {dly_r[0], bus_hold_request & ~revoke};
  end
  assign bus_hold_grant = dly_r[1];
  // io byte only while selected, otherwise a changing pattern
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) io_data <= 8'h00;
    else if (transfer_acknowledge_n != 4'hf)
      io_data <= {4'ha, ~transfer_acknowledge_n};
    else io_data <= ~io_data;
  end
endmodule

// [verif/dmaseq_top_test.sv]
// self-checking bench for the dma transfer sequencer
`timescale 1ns/1ps
module dmaseq_top_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] req = 4'h0;
  logic [3:0] en = 4'hf;
  logic rdy = 1'b1;
  logic mm = 1'b0;
  logic [1:0] cbits = 2'h0;
  logic revoke = 1'b0;
  logic grant, hold, ill, mval;
  logic mrd, mwr, ird, iwr, stall;
  logic mrdy = 1'b1;
  logic [3:0] ack;
  logic [7:0] iod, mdat;
  logic [1:0] chan;
  logic [7:0] last_byte = 8'h00;
  int err_count = 0;
  int check_count = 0;
  initial forever #25 clock = ~clock;
  dmaseq_top dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1),
    .transfer_request(req), .chan_enable(en), .bus_hold_grant(grant),
    .ready(rdy), .mem_mapped(mm), .cycle_bits(cbits), .io_data(iod),
    .mem_ready(mrdy), .bus_hold_request(hold),
    .transfer_acknowledge_n(ack), .mem_rd_n(mrd), .mem_wr_n(mwr),
    .io_rd_n(ird), .io_wr_n(iwr), .illegal_cycle(ill),
    .data_stall(stall), .active_chan(chan),
    .mem_data(mdat), .mem_data_valid(mval));
  dmaseq_host_model host (.clock(clock), .rst_b(rst_b),
    .bus_hold_request(hold), .revoke(revoke),
    .transfer_acknowledge_n(ack), .bus_hold_grant(grant), .io_data(iod));
  always @(posedge clock) if (mval === 1'b1) last_byte <= mdat;
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] obs(input int sel);
    if (sel == 0) return {7'h0, hold};
    return {4'h0, ack};
  endfunction
  // bounded wait; counts negedges until the watched output matches
  task automatic wt(input int sel, input logic [7:0] exp, output int n);
    n = 0;
    while (obs(sel) !== exp) begin
      @(negedge clock);
      n++;
      if (n > 60) begin
        chk("wait", exp, obs(sel));
        tally_and_finish;
      end
    end
  endtask
  task automatic sc_single;
    int n;
    req = 4'h2;
    wt(0, 8'h1, n);
    wt(1, 8'hd, n);
    chk("strobes", 8'h9, {4'h0, mrd, mwr, ird, iwr});
    req = 4'h0;
    wt(1, 8'hf, n);
    wt(0, 8'h0, n);
    repeat (8) @(negedge clock);
    chk("byte", 8'ha2, last_byte);
  endtask
  task automatic sc_prio;
    int a, b;
    req = 4'h5;
    wt(1, 8'he, a);
    chk("chan", 8'h0, {6'h0, chan});
    req = 4'h4;
    wt(1, 8'hb, a);
    chk("hold", 8'h1, {7'h0, hold});
    req = 4'h5;
    wt(1, 8'he, a);
    req = 4'h4;
    wt(1, 8'hb, a);
    wt(1, 8'hf, a);
    wt(1, 8'hb, b);
    chk("period", 8'h4, 8'(a + b));
    chk("hold", 8'h1, {7'h0, hold});
    req = 4'h0;
    wt(0, 8'h0, a);
  endtask
  task automatic sc_wait;
    int n;
    rdy = 1'b0;
    req = 4'h8;
    wt(1, 8'h7, n);
    req = 4'h0;
    repeat (8) @(negedge clock);
    chk("ack", 8'h7, {4'h0, ack});
    rdy = 1'b1;
    wt(1, 8'hf, n);
    chk("resume", 8'h1, {7'h0, n <= 4});
    wt(0, 8'h0, n);
  endtask
  task automatic sc_revoke;
    int n;
    req = 4'h2;
    wt(1, 8'hd, n);
    revoke = 1'b1;
    wt(0, 8'h0, n);
    wt(0, 8'h1, n);
    chk("rehold", 8'h3, 8'(n));
    revoke = 1'b0;
    wt(1, 8'hd, n);
    req = 4'h0;
    wt(0, 8'h0, n);
  endtask
  task automatic sc_dis;
    en = 4'h7;
    req = 4'h8;
    repeat (12) @(negedge clock);
    chk("hold", 8'h0, {7'h0, hold});
    chk("ack", 8'hf, {4'h0, ack});
    req = 4'h0;
    // let the synchronised request drain before re-enabling
    repeat (4) @(negedge clock);
    en = 4'hf;
  endtask
  task automatic sc_stall;
    int n;
    mrdy = 1'b0;
    req = 4'h1;
    repeat (40) @(negedge clock);
    chk("stall", 8'h1, {7'h0, stall});
    chk("ack", 8'he, {4'h0, ack});
    req = 4'h0;
    repeat (4) @(negedge clock);
    mrdy = 1'b1;
    wt(1, 8'hf, n);
    wt(0, 8'h0, n);
    repeat (4) @(negedge clock);
    chk("stall", 8'h0, {7'h0, stall});
  endtask
  task automatic sc_cyc;
    int n;
    mm = 1'b1;
    for (int c = 0; c < 4; c++) begin
      cbits = 2'(c);
      req = 4'h1;
      wt(1, 8'he, n);
      chk("strobes", c == 0 ? 8'h9 : (c == 2 ? 8'h6 : 8'hf),
        {4'h0, mrd, mwr, ird, iwr});
      req = 4'h0;
      wt(1, 8'hf, n);
      chk("illegal", {7'h0, c == 3}, {7'h0, ill});
      wt(0, 8'h0, n);
      repeat (4) @(negedge clock);
    end
    mm = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
    sc_single;
    sc_prio;
    sc_wait;
    sc_revoke;
    sc_dis;
    sc_stall;
    sc_cyc;
    tally_and_finish;
  end
endmodule
